// [rtl/msc_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module msc_regs #(
    parameter int FACTOR_W = 24,
    parameter int NCH = 32,
    parameter logic [15:0] MODULE_ID = 16'h1234, // arbitrary value
    parameter logic [3:0] VERSION = 4'h5, // arbitrary value
    parameter bit LARGE_FIFO = 1'b0
)(
    input wire logic clk,
    input wire logic rst_n,
    // register access port
    input wire logic [10:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic rvalid,
    // interrupt acknowledge
    input wire logic iack,
    output logic [7:0] iack_vector,
    // fifo side
    input wire logic fifo_full,
    input wire logic fifo_afull,
    input wire logic fifo_half,
    input wire logic fifo_aempty,
    input wire logic fifo_empty,
    input wire logic [31:0] fifo_rdata,
    output logic fifo_rd,
    output logic fifo_wr,
    output logic [31:0] fifo_wdata,
    output logic fifo_clear,
    // slice advance path
    input wire logic ext_adv,
    input wire logic copy_busy,
    output logic slice_advance,
    output logic copy_in_progress,
    output logic [5:0] copy_len,
    // control levels and test pulse
    output logic [31:0] ctrl_out,
    output logic [2:0] irq_level,
    output logic irq_master_en,
    output logic test_pulse
);
    // refuse sizes that the divider and copy decoder cannot serve
    if (FACTOR_W != 24 && FACTOR_W != 28)
    begin : g_bad_factor_w
        $error("factor width must be 24 or 28");
    end
    if (NCH != 32)
    begin : g_bad_nch
        $error("channel count must be 32");
    end

    logic [31:0] ctrl_r;
    logic [11:0] irqc_r;
    logic [31:0] copy_r;
    logic [FACTOR_W-1:0] factor_r;
    logic [FACTOR_W-1:0] pcnt_r;
    logic [4:0] div10_r;
    logic [2:0] div25_r;
    logic tp_r;
    logic wr_ctrl, key_rst, fifo_hit, src_tick, presc_tick, adv_req;
    logic [31:0] status;
    logic soft_adv;

    assign fifo_hit = addr >= msc_pkg::OFF_FIFO_LO
        && addr <= msc_pkg::OFF_FIFO_HI;
    assign wr_ctrl = wr_stb && addr == msc_pkg::OFF_CTRL;
    assign key_rst = wr_stb && addr == msc_pkg::OFF_KEY_RESET;

    // j/k control word; the master avoids set and clear together
    // set wins should both arrive, so the state is never left open
    always_ff @(posedge clk)
    begin
        if (!rst_n || key_rst)
            ctrl_r <= msc_pkg::CTRL_RST;
        else if (wr_ctrl)
        begin
            for (int i = 0; i < 8; i++)
            begin
                // low byte sets, next byte clears
                if (wdata[i]) ctrl_r[i] <= 1'b1;
                else if (wdata[i+msc_pkg::CLR_OFS]) ctrl_r[i] <= 1'b0;
                // byte 2 sets, byte 3 clears
                if (wdata[i+16]) ctrl_r[i+16] <= 1'b1;
                else if (wdata[i+16+msc_pkg::HI_CLR_OFS])
                    ctrl_r[i+16] <= 1'b0;
            end
        end
    end

    // interrupt control, id bits are constants and ignore writes
    always_ff @(posedge clk)
    begin
        if (!rst_n || key_rst)
            irqc_r <= 12'h000;
        else if (wr_stb && addr == msc_pkg::OFF_IDIRQ)
            irqc_r <= wdata[11:0];
    end

    // copy limit; upper seven bits fold onto bit 24 to save logic
    always_ff @(posedge clk)
    begin
        if (!rst_n || key_rst)
            copy_r <= 32'h0000_0000;
        else if (wr_stb && addr == msc_pkg::OFF_COPY)
            copy_r <= {{7{wdata[msc_pkg::COPY_FOLD]}}, wdata[24:0]};
    end

    // lowest set bit gives copy length; none set copies all channels
    // registered to give the long lowest-bit chain a whole cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            copy_len <= 6'h20;
        else
        begin
            copy_len <= 6'h20;
            for (int i = NCH - 1; i >= 0; i--)
                if (copy_r[i]) copy_len <= 6'(i);
        end
    end

    // prescale factor, read back at its own offset
    always_ff @(posedge clk)
    begin
        if (!rst_n || key_rst)
            factor_r <= '0;
        else if (wr_stb && addr == msc_pkg::OFF_FACTOR)
            factor_r <= wdata[FACTOR_W-1:0];
    end

    // 10 MHz and 25 MHz enables from the system clock
    always_ff @(posedge clk)
    begin
        if (!rst_n || div10_r == 5'(msc_pkg::INT_SRC_DIV - 1))
            div10_r <= 5'h00;
        else
            div10_r <= div10_r + 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div25_r <= 3'h0;
            tp_r <= 1'b0;
        end
        else
        begin
            div25_r <= div25_r + 3'h1;
            tp_r <= ctrl_r[msc_pkg::B_TPULSE]
                && div25_r == 3'(msc_pkg::TP_SRC_DIV - 1);
        end
    end

    // source select: internal 10 MHz or external advance
    assign src_tick = ctrl_r[msc_pkg::B_INT10] ? (div10_r == 5'h00)
        : (ext_adv && (ctrl_r[msc_pkg::B_EXT_ADV]
        || ctrl_r[msc_pkg::B_EXT_CLR]));

    // prescaler ratio factor+1; zero passes through
    // disabling clears the count, so a new factor starts a fresh period
    always_ff @(posedge clk)
    begin
        if (!rst_n || key_rst || !ctrl_r[msc_pkg::B_PRESC])
            pcnt_r <= '0;
        else if (src_tick)
            pcnt_r <= (pcnt_r >= factor_r) ? '0 : pcnt_r + FACTOR_W'(1);
    end
    assign presc_tick = ctrl_r[msc_pkg::B_PRESC] && src_tick
        && pcnt_r >= factor_r;

    // divided advances only count while the copy logic is free
    assign adv_req = presc_tick && !copy_busy;

    // software advance key bypasses prescaler and busy gate
    assign soft_adv = wr_stb && addr == msc_pkg::OFF_KEY_SOFT_ADV;

    // accepted advances; each one also flags a copy
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            slice_advance <= 1'b0;
            copy_in_progress <= 1'b0;
        end
        else
        begin
            slice_advance <= adv_req || soft_adv;
            copy_in_progress <= adv_req || soft_adv;
        end
    end

    // status word with fifo flags
    always_comb
    begin
        status = ctrl_r & 32'h00ff_00ff;
        status[msc_pkg::B_FIFO_FULL] = fifo_full;
        status[msc_pkg::B_FIFO_AFULL] = fifo_afull;
        status[msc_pkg::B_FIFO_HALF] = fifo_half;
        status[msc_pkg::B_FIFO_AEMPTY] = LARGE_FIFO ? !fifo_aempty
            : fifo_aempty;
        status[msc_pkg::B_FIFO_EMPTY] = fifo_empty;
    end

    // read mux, registered; unmapped reads give zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata <= 32'h0000_0000;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= rd_stb;
            if (rd_stb)
            begin
                if (addr == msc_pkg::OFF_CTRL)
                    rdata <= status;
                else if (addr == msc_pkg::OFF_IDIRQ)
                    rdata <= {MODULE_ID, VERSION, irqc_r};
                else if (addr == msc_pkg::OFF_FACTOR)
                    rdata <= 32'(factor_r);
                else if (fifo_hit)
                    rdata <= fifo_rdata;
                else
                    rdata <= 32'h0000_0000;
            end
        end
    end

    // fifo strobes and test-mode writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fifo_rd <= 1'b0;
            fifo_wr <= 1'b0;
            fifo_wdata <= 32'h0000_0000;
            fifo_clear <= 1'b0;
        end
        else
        begin
            fifo_rd <= rd_stb && fifo_hit;
            fifo_wr <= wr_stb && ctrl_r[msc_pkg::B_FTEST]
                && (fifo_hit || addr == msc_pkg::OFF_FIFO_WR);
            fifo_wdata <= wdata;
            fifo_clear <= key_rst
                || (wr_stb && addr == msc_pkg::OFF_KEY_FIFO_CLR);
        end
    end

    // registered copy of the control state for the rest of the scaler
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctrl_out <= 32'h0000_0000;
        else
            ctrl_out <= ctrl_r;
    end

    // interrupt level and master enable for the requester
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_level <= 3'h0;
            irq_master_en <= 1'b0;
        end
        else
        begin
            irq_level <= irqc_r[10:8];
            irq_master_en <= irqc_r[msc_pkg::B_IRQ_ENA];
        end
    end

    // vector only while acknowledged, so an idle bus reads zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            iack_vector <= 8'h00;
        else
            iack_vector <= iack ? irqc_r[7:0] : 8'h00;
    end

    // test pulses leave through a flop to keep the output glitch free
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            test_pulse <= 1'b0;
        else
            test_pulse <= tp_r;
    end
endmodule
`default_nettype wire

// [rtl/msc_pkg.sv]
package msc_pkg;
    localparam logic [10:0] OFF_CTRL = 11'h000;
    localparam logic [10:0] OFF_IDIRQ = 11'h004;
    localparam logic [10:0] OFF_COPY = 11'h00c;
    localparam logic [10:0] OFF_FIFO_WR = 11'h010;
    localparam logic [10:0] OFF_KEY_FIFO_CLR = 11'h020;
    localparam logic [10:0] OFF_KEY_SOFT_ADV = 11'h024;
    localparam logic [10:0] OFF_KEY_RESET = 11'h060;
    localparam logic [10:0] OFF_FACTOR = 11'h080;
    localparam logic [10:0] OFF_FIFO_LO = 11'h100;
    localparam logic [10:0] OFF_FIFO_HI = 11'h1fc;
    // control/status field positions
    localparam int B_LED = 0;
    localparam int B_FTEST = 1;
    localparam int B_MODE0 = 2;
    localparam int B_MODE1 = 3;
    localparam int B_TPULSE = 4;
    localparam int B_ITEST = 5;
    localparam int B_INT10 = 6;
    localparam int B_PRESC = 7;
    localparam int CLR_OFS = 8;
    localparam int B_EXT_ADV = 16;
    localparam int B_EXT_CLR = 17;
    localparam int B_EXT_INH = 18;
    localparam int B_SW_INH = 19;
    localparam int B_IRQ_EN0 = 20;
    localparam int HI_CLR_OFS = 8;
    localparam int B_FIFO_EMPTY = 8;
    localparam int B_FIFO_AEMPTY = 9;
    localparam int B_FIFO_HALF = 10;
    localparam int B_FIFO_AFULL = 11;
    localparam int B_FIFO_FULL = 12;
    localparam int B_IRQ_ENA = 11;
    localparam int ID_LSB = 12;
    localparam int COPY_FOLD = 24;
    // internal source is 10 MHz on a 200 MHz clock
    localparam int CLK_HZ = 200_000_000;
    localparam int INT_SRC_HZ = 10_000_000;
    localparam int INT_SRC_DIV = CLK_HZ / INT_SRC_HZ;
    localparam int TP_SRC_HZ = 25_000_000;
    localparam int TP_SRC_DIV = CLK_HZ / TP_SRC_HZ;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
endpackage

// [verif/msc_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module msc_regs_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [10:0] addr,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] wdata,
    input wire logic rvalid,
    // block outputs
    input wire logic fifo_rd,
    input wire logic fifo_wr,
    input wire logic [31:0] fifo_wdata,
    input wire logic fifo_clear,
    input wire logic slice_advance,
    input wire logic copy_in_progress,
    input wire logic [5:0] copy_len,
    input wire logic [31:0] ctrl_out,
    input wire logic [2:0] irq_level,
    input wire logic irq_master_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rv; rd_stb |=> rvalid; endproperty
    a_rv: assert property (p_rv)
        else $error("read not answered");
    property p_frd; rd_stb && addr >= msc_pkg::OFF_FIFO_LO
        && addr <= msc_pkg::OFF_FIFO_HI |=> fifo_rd; endproperty
    a_frd: assert property (p_frd)
        else $error("fifo window read missed");
    property p_fwr; wr_stb && addr == msc_pkg::OFF_FIFO_WR
        ##1 ctrl_out[msc_pkg::B_FTEST]
        |-> fifo_wr && fifo_wdata == $past(wdata); endproperty
    a_fwr: assert property (p_fwr)
        else $error("test-mode fifo write lost");
    property p_key; wr_stb && addr == msc_pkg::OFF_KEY_RESET
        |=> fifo_clear ##1 ctrl_out == 32'h0; endproperty
    a_key: assert property (p_key)
        else $error("key reset ignored");
    property p_soft; wr_stb && addr == msc_pkg::OFF_KEY_SOFT_ADV
        |=> slice_advance; endproperty
    a_soft: assert property (p_soft)
        else $error("soft advance missing");
    property p_copy; wr_stb && addr == msc_pkg::OFF_COPY && wdata[0]
        |=> ##1 copy_len == 6'h00; endproperty
    a_copy: assert property (p_copy)
        else $error("copy length wrong");
    property p_irq; wr_stb && addr == msc_pkg::OFF_IDIRQ
        |=> ##1 {irq_master_en, irq_level} == $past(wdata[11:8], 2);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq control not updated");
    property p_cip; slice_advance |-> copy_in_progress; endproperty
    a_cip: assert property (p_cip)
        else $error("accepted advance without copy pulse");
endmodule
bind msc_regs msc_regs_properties u_props (.*);
`default_nettype wire

// [verif/msc_fifo_model.sv]
`timescale 1ns/1ps
`default_nettype none
module msc_fifo_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests from the block
    input wire logic rd,
    input wire logic wr,
    input wire logic clr,
    input wire logic [31:0] wdata,
    // full, afull, half, aempty, empty and head word
    output logic [4:0] flags,
    output logic [31:0] rdata
);
    logic [31:0] q[$];
    logic [31:0] last = 32'h0;
    // depth 8 keeps every flag threshold reachable in a short run
    always @(posedge clk)
    begin
        if (!rst_n || clr)
            q.delete();
        else if (rd && q.size() > 0)
            last = q.pop_front();
        if (rst_n && !clr && wr && q.size() < 8)
            q.push_back(wdata);
        // pins settle after the edge, like a registered store
        flags <= {q.size() == 8, q.size() >= 6, q.size() >= 4,
            q.size() < 2, q.size() == 0};
        // an empty store shows no stale word
        rdata <= (q.size() == 0) ? ~last : q[0];
    end
endmodule
`default_nettype wire

// [verif/msc_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module msc_regs_tb;
    localparam logic [15:0] MID = 16'h4d2c; // arbitrary value
    localparam logic [3:0] VER = 4'h7; // arbitrary value
    logic clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, iack = 0;
    logic ext_adv = 0, copy_busy = 0, rvalid, fifo_rd, fifo_wr, fifo_clear;
    logic fifo_full, fifo_afull, fifo_half, fifo_aempty, fifo_empty;
    logic slice_advance, copy_in_progress, test_pulse, irq_master_en;
    logic [10:0] addr = 11'h000;
    logic [31:0] wdata = 32'h0, rdata, fifo_rdata, fifo_wdata, ctrl_out;
    logic [7:0] iack_vector;
    logic [5:0] copy_len;
    logic [2:0] irq_level;
    logic [31:0] lfsr = 32'h67ee8bba, ctl = 32'h0, d, r, e, fq[$];
    logic [31:0] ct[5] = '{32'h10, 32'h1, 32'h100_0000, 32'hfe00_0000, 32'h0};
    int num_errors = 0, num_checks = 0, sa_cnt = 0, tp_cnt = 0, cyc = 0, n;
    msc_regs #(.MODULE_ID(MID), .VERSION(VER)) uut (.*);
    msc_fifo_model fm (.clk(clk), .rst_n(rst_n), .rd(fifo_rd), .wr(fifo_wr),
        .clr(fifo_clear), .wdata(fifo_wdata), .rdata(fifo_rdata),
        .flags({fifo_full, fifo_afull, fifo_half, fifo_aempty, fifo_empty}));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // advance pulses counted here; ceiling well above the run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (slice_advance === 1'b1)
            sa_cnt <= sa_cnt + 1;
        if (test_pulse === 1'b1)
            tp_cnt <= tp_cnt + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // bus cycles start one step after an edge; an extra edge lets writes land
    task automatic wr(input logic [10:0] a, input logic [31:0] v);
        addr = a;
        wdata = v;
        wr_stb = 1;
        @(posedge clk);
        #1 wr_stb = 0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [10:0] a);
        addr = a;
        rd_stb = 1;
        @(posedge clk);
        #1 rd_stb = 0;
        r = rdata;
        @(posedge clk);
        #1;
    endtask
    task automatic adv(input int k);
        repeat (k)
        begin
            ext_adv = 1;
            @(posedge clk);
            #1 ext_adv = 0;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1;
        rd(msc_pkg::OFF_CTRL);
        chk(r & 32'h00ff1fff, 32'h0000_0300);
        // random set/clear words; a set bit never meets its own clear
        repeat (20)
        begin
            d = rnd();
            d[15:8] = d[15:8] & ~d[7:0];
            d[31:24] = d[31:24] & ~d[23:16];
            ctl = (ctl | (d & 32'hff00ff)) & ~((d >> 8) & 32'hff00ff);
            wr(msc_pkg::OFF_CTRL, d);
            chk(ctrl_out & 32'h00ff00ff, ctl);
            rd(msc_pkg::OFF_CTRL);
            e = ctl;
            e[12:8] = {fifo_full, fifo_afull, fifo_half, fifo_aempty, fifo_empty};
            chk(r & 32'h00ff1fff, e);
        end
        $display("test control done");
        d = rnd();
        wr(msc_pkg::OFF_IDIRQ, d);
        rd(msc_pkg::OFF_IDIRQ);
        chk(r, {MID, VER, d[11:0]});
        iack = 1;
        repeat (2) @(posedge clk);
        #1 chk(32'(iack_vector), 32'(d[7:0]));
        iack = 0;
        foreach (ct[i])
        begin
            wr(msc_pkg::OFF_COPY, ct[i]);
            n = 32;
            for (int b = 24; b >= 0; b--)
                if (ct[i][b]) n = b;
            chk(32'(copy_len), n);
        end
        wr(msc_pkg::OFF_CTRL, 32'h0000_0010);
        repeat (4) @(posedge clk);
        #1 n = tp_cnt;
        repeat (80) @(posedge clk);
        #1 chk(tp_cnt - n, 10);
        wr(msc_pkg::OFF_CTRL, 32'h0000_1000);
        repeat (4) @(posedge clk);
        #1 n = tp_cnt;
        repeat (16) @(posedge clk);
        #1 chk(tp_cnt - n, 0);
        $display("test id and copy done");
        wr(msc_pkg::OFF_CTRL, 32'h0000_0002);
        repeat (3)
        begin
            fq.push_back(rnd());
            wr(msc_pkg::OFF_FIFO_WR, fq[$]);
        end
        rd(msc_pkg::OFF_CTRL);
        chk(r & 32'h0000_1f00, 32'h0);
        foreach (ct[i])
        begin
            if (i < 3)
            begin
                rd(11'h100 + (11'(i * 'h7e) & 11'h7fc)); // 0x100 0x17c 0x1fc
                chk(r, fq.pop_front());
            end
        end
        $display("test fifo done");
        wr(msc_pkg::OFF_CTRL, 32'hff00ff00);
        d = rnd() & 32'h00ff_ffff;
        wr(msc_pkg::OFF_FACTOR, d);
        rd(msc_pkg::OFF_FACTOR);
        chk(r, d);
        wr(msc_pkg::OFF_FACTOR, 32'h2);
        wr(msc_pkg::OFF_CTRL, 32'h0001_0080);
        n = sa_cnt;
        adv(9);
        chk(sa_cnt - n, 3);
        copy_busy = 1;
        adv(3);
        chk(sa_cnt - n, 3);
        copy_busy = 0;
        wr(msc_pkg::OFF_CTRL, 32'h0000_8000);
        wr(msc_pkg::OFF_FACTOR, 32'h0);
        wr(msc_pkg::OFF_CTRL, 32'h0000_0080);
        adv(4);
        wr(msc_pkg::OFF_KEY_SOFT_ADV, rnd());
        repeat (3) @(posedge clk);
        #1 chk(sa_cnt - n, 8);
        copy_busy = 1;
        wr(msc_pkg::OFF_KEY_SOFT_ADV, rnd());
        copy_busy = 0;
        repeat (2) @(posedge clk);
        #1 chk(sa_cnt - n, 9);
        $display("test prescaler done");
        rd(11'h7f0);
        chk(r, 32'h0);
        wr(msc_pkg::OFF_COPY, 32'h0000_0004);
        wr(msc_pkg::OFF_FACTOR, 32'h0000_0005);
        wr(msc_pkg::OFF_KEY_RESET, rnd());
        rd(msc_pkg::OFF_CTRL);
        chk(r & 32'h00ff1fff, 32'h0000_0300);
        chk(32'(copy_len), 32);
        chk(ctrl_out, 32'h0);
        rd(msc_pkg::OFF_FACTOR);
        chk(r, 32'h0);
        rd(msc_pkg::OFF_IDIRQ);
        chk(r, {MID, VER, 12'h000});
        $display("test key reset done");
        test_done;
    end
endmodule
`default_nettype wire
